// ===== verilog/srwi_pkg.sv
// Package for the secure region host controller: register map, pin bundles, timing.
package srwi_pkg;

  // Own register map, byte addresses on AHB-Lite
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_ADDR_OFS   = 8'h04;
  localparam logic [7:0] REG_WDATA_OFS  = 8'h08;
  localparam logic [7:0] REG_STATUS_OFS = 8'h0C;
  localparam logic [7:0] REG_RDATA_OFS  = 8'h10;

  // Command codes written to the control register
  localparam logic [3:0] CMD_READ        = 4'h1;
  localparam logic [3:0] CMD_ENTER       = 4'h2;
  localparam logic [3:0] CMD_EXIT        = 4'h3;
  localparam logic [3:0] CMD_PROGRAM     = 4'h4;
  localparam logic [3:0] CMD_LOCK        = 4'h5;
  localparam logic [3:0] CMD_VERIFY      = 4'h6;
  localparam logic [3:0] CMD_RESET_FLASH = 4'h7;

  // Status field positions
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_REGION_BIT  = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_PROT_BIT    = 3;
  localparam int ST_FLOCK_BIT   = 4;
  localparam int ST_CLOCK_BIT   = 5;

  // Region geometry in word addresses, and flag bit positions in a region word
  localparam logic [22:0] REGION_LAST      = 23'h00007F;
  localparam logic [22:0] CUSTOMER_FIRST   = 23'h000040;
  localparam logic [22:0] VERIFY_ADDR      = 23'h000002;
  localparam int          FACTORY_FLAG_POS = 7;
  localparam int          CUSTOMER_FLAG_POS = 6;

  // Command sequence words
  localparam logic [22:0] UNLOCK_A1    = 23'h000555;
  localparam logic [22:0] UNLOCK_A2    = 23'h0002AA;
  localparam logic [15:0] UNLOCK_D1    = 16'h00AA;
  localparam logic [15:0] UNLOCK_D2    = 16'h0055;
  localparam logic [15:0] ENTER_D      = 16'h0088;
  localparam logic [15:0] EXIT_D       = 16'h0090;
  localparam logic [15:0] EXIT_D2      = 16'h0000;
  localparam logic [15:0] PROGRAM_D    = 16'h00A0;
  localparam logic [15:0] RESET_D      = 16'h00F0;
  localparam logic [15:0] PROT_SETUP_D = 16'h0060;
  localparam logic [15:0] PROT_STEP_D  = 16'h0040;
  localparam logic [15:0] VERIFY_PROT  = 16'h0001;

  // Timing: clock period, strobe width, verify wait
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STROBE_NS      = 60;
  localparam int VERIFY_WAIT_NS = 1000;
  localparam int GLITCH_NS      = 3;
  localparam int STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VERIFY_CYC     = (VERIFY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CYC     = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic        cs_n;
    logic        we_n;
    logic        oe_n;
    logic        reset_n;
    logic [22:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe;
  } srwi_pins_t;

  typedef struct packed {
    logic        go;
    logic        write;
    logic [22:0] addr;
    logic [15:0] data;
  } srwi_cycle_t;

endpackage : srwi_pkg

// ===== verilog/srwi_cycle.sv
// Single flash bus cycle sequencer: one write or one read on the parallel pins.
`timescale 1ns/10ps
module srwi_cycle (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire srwi_pkg::srwi_cycle_t req_in,
  input  wire logic [15:0]           dq_in,
  output srwi_pkg::srwi_pins_t       pins_out,
  output logic                       done_out,
  output logic [15:0]                rdata_out
);

  typedef enum logic [1:0] {SRWI_C_IDLE, SRWI_C_SETUP, SRWI_C_STROBE, SRWI_C_HOLD} srwi_cst_t;

  srwi_cst_t   state_reg;
  logic [7:0]  cnt_reg;
  logic        write_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= SRWI_C_IDLE;
      cnt_reg   <= 8'h00;
      write_reg <= 1'b0;
      done_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (state_reg)
        SRWI_C_IDLE: begin
          if (req_in.go) begin
            write_reg <= req_in.write;
            state_reg <= SRWI_C_SETUP;
          end
        end
        SRWI_C_SETUP: begin
          cnt_reg   <= 8'(srwi_pkg::STROBE_CYC);
          state_reg <= SRWI_C_STROBE;
        end
        SRWI_C_STROBE: begin
          // Strobe far wider than the glitch filter, so the device sees a real cycle
          if (cnt_reg == 8'h01) begin
            state_reg <= SRWI_C_HOLD;
          end
          cnt_reg <= cnt_reg - 8'h01;
        end
        SRWI_C_HOLD: begin
          done_out  <= 1'b1;
          state_reg <= SRWI_C_IDLE;
        end
      endcase
    end
  end

  // Pin drive: address and data set up a cycle before strobes, held a cycle after
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pins_out.cs_n    <= 1'b1;
      pins_out.we_n    <= 1'b1;
      pins_out.oe_n    <= 1'b1;
      pins_out.reset_n <= 1'b0;
      pins_out.addr    <= 23'h000000;
      pins_out.dq_o    <= 16'h0000;
      pins_out.dq_oe   <= 1'b0;
      rdata_out        <= 16'h0000;
    end else begin
      pins_out.reset_n <= 1'b1;
      if (state_reg == SRWI_C_IDLE && req_in.go) begin
        pins_out.addr  <= req_in.addr;
        pins_out.dq_o  <= req_in.data;
        pins_out.dq_oe <= req_in.write;
        pins_out.cs_n  <= 1'b0;
        pins_out.oe_n  <= 1'b1;
        pins_out.we_n  <= 1'b1;
      end else if (state_reg == SRWI_C_SETUP) begin
        // A write keeps output enable high while select and strobe are low
        pins_out.we_n <= ~write_reg;
        pins_out.oe_n <= write_reg;
      end else if (state_reg == SRWI_C_STROBE && cnt_reg == 8'h01) begin
        pins_out.we_n <= 1'b1;
        pins_out.oe_n <= 1'b1;
        if (!write_reg) begin
          rdata_out <= dq_in;
        end
      end else if (state_reg == SRWI_C_HOLD) begin
        pins_out.cs_n  <= 1'b1;
        pins_out.dq_oe <= 1'b0;
      end
    end
  end

endmodule : srwi_cycle

// ===== verilog/srwi_host.sv
// Host controller for the flash secure id region, commanded over AHB-Lite.
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module srwi_host (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HSEL_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic [15:0] FLASH_DQ_IN,
  output logic [15:0]      FLASH_DQ_OUT,
  output logic             FLASH_DQ_OE_OUT,
  output logic [22:0]      FLASH_ADDR_OUT,
  output logic             FLASH_CS_N_OUT,
  output logic             FLASH_WE_N_OUT,
  output logic             FLASH_OE_N_OUT,
  output logic             FLASH_RESET_N_OUT
);

  typedef enum logic [2:0] {SRWI_IDLE, SRWI_ISSUE, SRWI_WAIT, SRWI_DELAY, SRWI_FINISH} srwi_st_t;

  srwi_st_t              state_reg;
  logic [3:0]            cmd_reg;
  logic [2:0]            step_reg;
  logic [22:0]           addr_reg;
  logic [15:0]           wdata_reg;
  logic [15:0]           rdata_reg;
  logic                  region_reg;
  logic                  refused_reg;
  logic                  prot_reg;
  logic [7:0]            dly_reg;
  logic                  ph_valid_reg;
  logic                  ph_write_reg;
  logic [7:0]            ph_addr_reg;
  srwi_pkg::srwi_cycle_t cyc_req;
  srwi_pkg::srwi_pins_t  pins;
  logic                  cyc_done;
  logic [15:0]           cyc_rdata;
  logic [2:0]            last_step;
  logic                  busy;

  assign busy = (state_reg != SRWI_IDLE);

  // Number of bus cycles each command needs, less one
  function automatic logic [2:0] srwi_last(input logic [3:0] cmd);
    unique case (cmd)
      srwi_pkg::CMD_READ:        srwi_last = 3'h0;
      srwi_pkg::CMD_ENTER:       srwi_last = 3'h2;
      srwi_pkg::CMD_EXIT:        srwi_last = 3'h3;
      srwi_pkg::CMD_PROGRAM:     srwi_last = 3'h3;
      srwi_pkg::CMD_LOCK:        srwi_last = 3'h2;
      srwi_pkg::CMD_VERIFY:      srwi_last = 3'h2;
      default:                   srwi_last = 3'h0;
    endcase
  endfunction : srwi_last

  function automatic logic in_region(input logic [22:0] a);
    in_region = (a <= srwi_pkg::REGION_LAST);
  endfunction : in_region

  assign last_step = srwi_last(cmd_reg);

  // Build each bus cycle of the current command
  always_comb begin
    cyc_req       = '0;
    cyc_req.go    = (state_reg == SRWI_ISSUE);
    cyc_req.write = 1'b1;
    unique case (cmd_reg)
      srwi_pkg::CMD_ENTER, srwi_pkg::CMD_EXIT, srwi_pkg::CMD_PROGRAM: begin
        // Full unlock pair ahead of every command word
        unique case (step_reg)
          3'h0: begin
            cyc_req.addr = srwi_pkg::UNLOCK_A1;
            cyc_req.data = srwi_pkg::UNLOCK_D1;
          end
          3'h1: begin
            cyc_req.addr = srwi_pkg::UNLOCK_A2;
            cyc_req.data = srwi_pkg::UNLOCK_D2;
          end
          3'h2: begin
            cyc_req.addr = srwi_pkg::UNLOCK_A1;
            cyc_req.data = (cmd_reg == srwi_pkg::CMD_ENTER) ? srwi_pkg::ENTER_D :
                           (cmd_reg == srwi_pkg::CMD_EXIT) ? srwi_pkg::EXIT_D :
                           srwi_pkg::PROGRAM_D;
          end
          default: begin
            cyc_req.addr = (cmd_reg == srwi_pkg::CMD_EXIT) ? 23'h000000 : addr_reg;
            cyc_req.data = (cmd_reg == srwi_pkg::CMD_EXIT) ? srwi_pkg::EXIT_D2 : wdata_reg;
          end
        endcase
      end
      srwi_pkg::CMD_LOCK, srwi_pkg::CMD_VERIFY: begin
        if (step_reg == 3'h0) begin
          cyc_req.addr = srwi_pkg::VERIFY_ADDR;
          cyc_req.data = srwi_pkg::PROT_SETUP_D;
        end else if (step_reg == 3'h1) begin
          cyc_req.addr = srwi_pkg::VERIFY_ADDR;
          cyc_req.data = srwi_pkg::PROT_STEP_D;
        end else begin
          cyc_req.write = 1'b0;
          cyc_req.addr  = srwi_pkg::VERIFY_ADDR;
        end
      end
      srwi_pkg::CMD_RESET_FLASH: begin
        cyc_req.addr = 23'h000000;
        cyc_req.data = srwi_pkg::RESET_D;
      end
      default: begin
        cyc_req.write = 1'b0;
        cyc_req.addr  = addr_reg;
      end
    endcase
  end

  srwi_cycle u_cycle (
    .clk_in    (CORE_CLK_IN),
    .rst_in    (RST_IN),
    .req_in    (cyc_req),
    .dq_in     (FLASH_DQ_IN),
    .pins_out  (pins),
    .done_out  (cyc_done),
    .rdata_out (cyc_rdata)
  );

  // Command sequencer
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      state_reg   <= SRWI_IDLE;
      step_reg    <= 3'h0;
      dly_reg     <= 8'h00;
      rdata_reg   <= 16'h0000;
      refused_reg <= 1'b0;
      prot_reg    <= 1'b0;
    end else begin
      unique case (state_reg)
        SRWI_IDLE: begin
          if (ph_valid_reg && ph_write_reg && ph_addr_reg == srwi_pkg::REG_CTRL_OFS) begin
            refused_reg <= 1'b0;
            step_reg    <= 3'h0;
            // In region mode, writes to the factory half, or to the customer half once locked, go nowhere
            if (HWDATA_IN[3:0] == srwi_pkg::CMD_PROGRAM &&
                region_reg && in_region(addr_reg) &&
                (addr_reg < srwi_pkg::CUSTOMER_FIRST || prot_reg)) begin
              refused_reg <= 1'b1;
            end else if ((HWDATA_IN[3:0] == srwi_pkg::CMD_LOCK ||
                          HWDATA_IN[3:0] == srwi_pkg::CMD_VERIFY) && !region_reg) begin
              refused_reg <= 1'b1;
            end else if (HWDATA_IN[3:0] != 4'h0 && HWDATA_IN[3:0] <= srwi_pkg::CMD_RESET_FLASH) begin
              state_reg <= SRWI_ISSUE;
            end
          end
        end
        SRWI_ISSUE: state_reg <= SRWI_WAIT;
        SRWI_WAIT: begin
          if (cyc_done) begin
            if (step_reg == 3'h1 && (cmd_reg == srwi_pkg::CMD_LOCK ||
                                     cmd_reg == srwi_pkg::CMD_VERIFY)) begin
              dly_reg   <= 8'(srwi_pkg::VERIFY_CYC);
              state_reg <= SRWI_DELAY;
            end else if (step_reg == last_step) begin
              state_reg <= SRWI_FINISH;
            end else begin
              state_reg <= SRWI_ISSUE;
            end
            step_reg <= step_reg + 3'h1;
          end
        end
        SRWI_DELAY: begin
          if (dly_reg == 8'h01) begin
            state_reg <= SRWI_ISSUE;
          end
          dly_reg <= dly_reg - 8'h01;
        end
        SRWI_FINISH: begin
          if (cmd_reg == srwi_pkg::CMD_READ) begin
            rdata_reg <= cyc_rdata;
          end
          if (cmd_reg == srwi_pkg::CMD_LOCK || cmd_reg == srwi_pkg::CMD_VERIFY) begin
            rdata_reg <= cyc_rdata;
            prot_reg  <= (cyc_rdata[7:0] == srwi_pkg::VERIFY_PROT[7:0]);
            refused_reg <= (cmd_reg == srwi_pkg::CMD_LOCK) &&
                           (cyc_rdata[7:0] != srwi_pkg::VERIFY_PROT[7:0]);
          end
          state_reg <= SRWI_IDLE;
        end
      endcase
    end
  end

  // Region mode tracking; controller reset drops it as well, the flash reset command keeps it
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      region_reg <= 1'b0;
    end else if (state_reg == SRWI_FINISH) begin
      if (cmd_reg == srwi_pkg::CMD_ENTER) begin
        region_reg <= 1'b1;
      end else if (cmd_reg == srwi_pkg::CMD_EXIT) begin
        region_reg <= 1'b0;
      end
    end
  end

  // Software registers
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      cmd_reg   <= 4'h0;
      addr_reg  <= 23'h000000;
      wdata_reg <= 16'h0000;
    end else if (ph_valid_reg && ph_write_reg && !busy) begin
      if (ph_addr_reg == srwi_pkg::REG_CTRL_OFS) begin
        cmd_reg <= HWDATA_IN[3:0];
      end
      if (ph_addr_reg == srwi_pkg::REG_ADDR_OFS) begin
        addr_reg <= HWDATA_IN[22:0];
      end
      if (ph_addr_reg == srwi_pkg::REG_WDATA_OFS) begin
        wdata_reg <= HWDATA_IN[15:0];
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      ph_valid_reg  <= 1'b0;
      ph_write_reg  <= 1'b0;
      ph_addr_reg   <= 8'h00;
      HRDATA_OUT    <= 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      ph_valid_reg <= HSEL_IN && HREADY_IN && HTRANS_IN[1];
      ph_write_reg <= HWRITE_IN;
      ph_addr_reg  <= HADDR_IN[7:0];
      HRDATA_OUT   <= 32'h00000000;
      if (HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN) begin
        unique case (HADDR_IN[7:0])
          srwi_pkg::REG_CTRL_OFS:   HRDATA_OUT <= {28'h0000000, cmd_reg};
          srwi_pkg::REG_ADDR_OFS:   HRDATA_OUT <= {9'h000, addr_reg};
          srwi_pkg::REG_WDATA_OFS:  HRDATA_OUT <= {16'h0000, wdata_reg};
          srwi_pkg::REG_STATUS_OFS: HRDATA_OUT <= {26'h0000000, rdata_reg[srwi_pkg::CUSTOMER_FLAG_POS],
                                                   rdata_reg[srwi_pkg::FACTORY_FLAG_POS],
                                                   prot_reg, refused_reg, region_reg, busy};
          srwi_pkg::REG_RDATA_OFS:  HRDATA_OUT <= {16'h0000, rdata_reg};
          default:                  HRDATA_OUT <= 32'h00000000;
        endcase
      end
    end
  end

  // Pin outputs get a second register here, after the one inside the cycle sequencer
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      FLASH_DQ_OUT      <= 16'h0000;
      FLASH_DQ_OE_OUT   <= 1'b0;
      FLASH_ADDR_OUT    <= 23'h000000;
      FLASH_CS_N_OUT    <= 1'b1;
      FLASH_WE_N_OUT    <= 1'b1;
      FLASH_OE_N_OUT    <= 1'b1;
      FLASH_RESET_N_OUT <= 1'b0;
    end else begin
      FLASH_DQ_OUT      <= pins.dq_o;
      FLASH_DQ_OE_OUT   <= pins.dq_oe;
      FLASH_ADDR_OUT    <= pins.addr;
      FLASH_CS_N_OUT    <= pins.cs_n;
      FLASH_WE_N_OUT    <= pins.we_n;
      FLASH_OE_N_OUT    <= pins.oe_n;
      FLASH_RESET_N_OUT <= pins.reset_n;
    end
  end

endmodule : srwi_host

// ===== tb/srwi_host_props.sv
// Concurrent checks on the flash pins and bus response of the secure region host.
`timescale 1ns/10ps
module srwi_host_props (
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_IN,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic [15:0] FLASH_DQ_OUT,
  input wire logic        FLASH_DQ_OE_OUT,
  input wire logic [22:0] FLASH_ADDR_OUT,
  input wire logic        FLASH_CS_N_OUT,
  input wire logic        FLASH_WE_N_OUT,
  input wire logic        FLASH_OE_N_OUT,
  input wire logic        FLASH_RESET_N_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  // Cycles since the last write strobe ended, saturating so it never wraps
  logic [7:0] gap_reg;
  logic       was40_reg;
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      gap_reg   <= 8'h00;
      was40_reg <= 1'b0;
    end else if ($rose(FLASH_WE_N_OUT)) begin
      gap_reg   <= 8'h00;
      was40_reg <= (FLASH_DQ_OUT == 16'h0040);
    end else if (gap_reg != 8'hFF) begin
      gap_reg <= gap_reg + 8'h01;
    end
  end
  a_reset_pins: assert property ($fell(RST_IN) |-> FLASH_CS_N_OUT && FLASH_WE_N_OUT
    && FLASH_OE_N_OUT && !FLASH_RESET_N_OUT && !FLASH_DQ_OE_OUT) else $error("pins not idle at reset");
  a_reset_release: assert property ($fell(RST_IN) |-> ##[1:3] FLASH_RESET_N_OUT)
    else $error("flash reset not released");
  a_strobe_select: assert property (!FLASH_WE_N_OUT || !FLASH_OE_N_OUT |->
    !FLASH_CS_N_OUT && FLASH_RESET_N_OUT) else $error("strobe without select");
  a_no_contention: assert property (!FLASH_OE_N_OUT |-> !FLASH_DQ_OE_OUT && FLASH_WE_N_OUT)
    else $error("read while driving or writing");
  a_write_drives: assert property (!FLASH_WE_N_OUT |-> FLASH_DQ_OE_OUT)
    else $error("write strobe without data drive");
  a_we_width: assert property ($fell(FLASH_WE_N_OUT) |-> (!FLASH_WE_N_OUT)[*6] ##1 FLASH_WE_N_OUT)
    else $error("write strobe width wrong");
  a_oe_width: assert property ($fell(FLASH_OE_N_OUT) |-> (!FLASH_OE_N_OUT)[*6] ##1 FLASH_OE_N_OUT)
    else $error("read strobe width wrong");
  a_addr_hold: assert property (!FLASH_WE_N_OUT && !$past(FLASH_WE_N_OUT) |->
    $stable(FLASH_ADDR_OUT) && $stable(FLASH_DQ_OUT)) else $error("address or data moved in write");
  a_cs_release: assert property ($rose(FLASH_WE_N_OUT) |=> FLASH_CS_N_OUT && !FLASH_DQ_OE_OUT)
    else $error("select or drive held after write");
  a_verify_wait: assert property ($fell(FLASH_OE_N_OUT) && was40_reg |-> gap_reg >= 8'h63)
    else $error("verify read too soon");
  a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus response not ready okay");
  c_write: cover property ($fell(FLASH_WE_N_OUT));
  c_read: cover property ($fell(FLASH_OE_N_OUT));
  c_verify: cover property ($fell(FLASH_OE_N_OUT) && was40_reg);
endmodule : srwi_host_props
bind srwi_host srwi_host_props u_props (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .FLASH_DQ_OUT(FLASH_DQ_OUT),
  .FLASH_DQ_OE_OUT(FLASH_DQ_OE_OUT), .FLASH_ADDR_OUT(FLASH_ADDR_OUT),
  .FLASH_CS_N_OUT(FLASH_CS_N_OUT), .FLASH_WE_N_OUT(FLASH_WE_N_OUT),
  .FLASH_OE_N_OUT(FLASH_OE_N_OUT), .FLASH_RESET_N_OUT(FLASH_RESET_N_OUT));

// ===== tb/srwi_flash_model.sv
// Behavioural flash device with the secure id region, seen from its pins.
`timescale 1ns/10ps
module srwi_flash_model (
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        reset_n_in,
  input  wire logic        lock_fail_in,
  input  wire logic [22:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out
);
  logic [15:0] region [0:127];
  logic [1:0]  step;
  logic        region_mode, cust_lock, prog_armed, prot_setup, verify_rd;
  logic [15:0] last_q;
  initial begin
    for (int i = 0; i < 128; i++) region[i] = (i < 64) ? 16'hA500 | i : 16'hFF3F;
    cust_lock = 1'b0;
    region_mode = 1'b0;
    {step, prog_armed, prot_setup, verify_rd} = '0;
    last_q = 16'h0000;
  end
  always @(negedge reset_n_in) begin
    {region_mode, step, prog_armed, prot_setup, verify_rd} = '0;
  end
  // Only a completed select-and-strobe cycle with output enable high counts
  always @(posedge we_n_in) if (!cs_n_in && oe_n_in && reset_n_in) begin
    verify_rd = 1'b0;
    if (prog_armed) begin
      prog_armed = 1'b0;
      // Factory half and a locked customer half never change
      if (region_mode && addr_in >= 23'h40 && addr_in <= 23'h7F && !cust_lock)
        region[addr_in[6:0]] = region[addr_in[6:0]] & dq_in;
    end else if (prot_setup) begin
      prot_setup = 1'b0;
      if (dq_in == 16'h0040 && !addr_in[6] && addr_in[1:0] == 2'b10) begin
        verify_rd = 1'b1;
        if (region_mode && !lock_fail_in) cust_lock = 1'b1;
      end
    end else if (dq_in == 16'h0060) prot_setup = 1'b1;
    else if (step == 2'd0 && addr_in == 23'h555 && dq_in == 16'h00AA) step = 2'd1;
    else if (step == 2'd1 && addr_in == 23'h2AA && dq_in == 16'h0055) step = 2'd2;
    else if (step == 2'd2 && addr_in == 23'h555) begin
      step = 2'd0;
      if (dq_in == 16'h0088) region_mode = 1'b1;
      if (dq_in == 16'h0090) region_mode = 1'b0;
      if (dq_in == 16'h00A0) prog_armed = 1'b1;
    end else step = 2'd0;
  end
  always @* begin
    if (!cs_n_in && !oe_n_in) begin
      if (verify_rd) dq_out = {15'h0000, cust_lock};
      else if (region_mode && addr_in <= 23'h7F)
        dq_out = region[addr_in[6:0]] | (addr_in[6] ? {9'h000, cust_lock, 6'h00} : 16'h0080);
      else dq_out = 16'h3C00 | {8'h00, addr_in[7:0]};
    end else dq_out = ~last_q;
  end
  // Released bus shows the inverse of the last value, not a stale copy
  always @(dq_out) if (!cs_n_in && !oe_n_in) last_q = dq_out;
endmodule : srwi_flash_model

// ===== tb/test_srwi_host.sv
// Self-checking testbench for the secure region host controller.
`timescale 1ns/10ps
module test_srwi_host;
  logic        clk = 1'b0, rst = 1'b1, hwrite = 1'b0, lock_fail = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st, d;
  logic        hready, hresp, dq_oe, cs_n, we_n, oe_n, freset_n;
  logic [15:0] dq_out, mdl_dq;
  wire  [15:0] dq_bus = dq_oe ? dq_out : mdl_dq;
  logic [22:0] faddr;
  int          bad_count = 0, comparisons = 0;
  always #5 clk = ~clk;
  srwi_host dut_u (.CORE_CLK_IN(clk), .RST_IN(rst), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata), .HSEL_IN(1'b1),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .FLASH_DQ_IN(dq_bus), .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE_OUT(dq_oe),
    .FLASH_ADDR_OUT(faddr), .FLASH_CS_N_OUT(cs_n), .FLASH_WE_N_OUT(we_n),
    .FLASH_OE_N_OUT(oe_n), .FLASH_RESET_N_OUT(freset_n));
  srwi_flash_model flash_u (.cs_n_in(cs_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .reset_n_in(freset_n), .lock_fail_in(lock_fail), .addr_in(faddr), .dq_in(dq_bus),
    .dq_out(mdl_dq));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_ready
  // One single word transfer; data phase follows the accepted address phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb
  task automatic run_cmd(input logic [3:0] c, input logic [22:0] a, input logic [15:0] wd);
    int n;
    ahb(1'b1, srwi_pkg::REG_ADDR_OFS, {9'h000, a}, d);
    ahb(1'b1, srwi_pkg::REG_WDATA_OFS, {16'h0000, wd}, d);
    ahb(1'b1, srwi_pkg::REG_CTRL_OFS, {28'h0000000, c}, d);
    n = 0;
    do begin
      ahb(1'b0, srwi_pkg::REG_STATUS_OFS, 32'h0, st);
      n++;
    end while (st[srwi_pkg::ST_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      bad_count++;
      report_and_stop();
    end
  endtask : run_cmd
  task automatic flash_read(input logic [22:0] a);
    run_cmd(srwi_pkg::CMD_READ, a, 16'h0000);
    ahb(1'b0, srwi_pkg::REG_RDATA_OFS, 32'h0, d);
  endtask : flash_read
  task automatic do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic t_main;
    ahb(1'b0, 8'h14, 32'h0, d);
    check("unmapped", d, 32'h0);
    flash_read(23'h10);
    check("main word", d, 32'h3C10);
    check("region flag", st[srwi_pkg::ST_REGION_BIT], 1'b0);
  endtask : t_main
  task automatic t_enter;
    run_cmd(srwi_pkg::CMD_ENTER, 23'h0, 16'h0000);
    check("region on", st[srwi_pkg::ST_REGION_BIT], 1'b1);
    flash_read(23'h10);
    check("factory word", d, 32'hA590);
    check("factory flag", st[srwi_pkg::ST_FLOCK_BIT], 1'b1);
    flash_read(23'h7F);
    check("last word", d, 32'hFF3F);
    check("customer flag", st[srwi_pkg::ST_CLOCK_BIT], 1'b0);
  endtask : t_enter
  task automatic t_program;
    run_cmd(srwi_pkg::CMD_PROGRAM, 23'h03, 16'h0000);
    check("factory refused", st[srwi_pkg::ST_REFUSED_BIT], 1'b1);
    flash_read(23'h03);
    check("factory kept", d, 32'hA583);
    run_cmd(srwi_pkg::CMD_PROGRAM, 23'h41, 16'h1234);
    check("customer taken", st[srwi_pkg::ST_REFUSED_BIT], 1'b0);
    flash_read(23'h41);
    check("customer word", d, 32'h1234);
  endtask : t_program
  task automatic t_lock;
    lock_fail <= 1'b1;
    run_cmd(srwi_pkg::CMD_LOCK, 23'h0, 16'h0000);
    check("lock fails", st[srwi_pkg::ST_REFUSED_BIT], 1'b1);
    run_cmd(srwi_pkg::CMD_VERIFY, 23'h0, 16'h0000);
    check("verify open", st[srwi_pkg::ST_PROT_BIT], 1'b0);
    lock_fail <= 1'b0;
    run_cmd(srwi_pkg::CMD_LOCK, 23'h0, 16'h0000);
    check("lock done", st[srwi_pkg::ST_REFUSED_BIT], 1'b0);
    run_cmd(srwi_pkg::CMD_VERIFY, 23'h0, 16'h0000);
    check("verify locked", st[srwi_pkg::ST_PROT_BIT], 1'b1);
    // Device stays in verify read until its next write, here the reset word, so reads would see the status
    run_cmd(srwi_pkg::CMD_RESET_FLASH, 23'h0, 16'h0000);
    check("reset keeps region", st[srwi_pkg::ST_REGION_BIT], 1'b1);
    run_cmd(srwi_pkg::CMD_PROGRAM, 23'h42, 16'h0000);
    check("locked refused", st[srwi_pkg::ST_REFUSED_BIT], 1'b1);
    flash_read(23'h42);
    check("locked word", d, 32'hFF7F);
    check("customer flag set", st[srwi_pkg::ST_CLOCK_BIT], 1'b1);
  endtask : t_lock
  task automatic t_exit;
    run_cmd(srwi_pkg::CMD_EXIT, 23'h0, 16'h0000);
    check("region off", st[srwi_pkg::ST_REGION_BIT], 1'b0);
    flash_read(23'h10);
    check("main back", d, 32'h3C10);
    run_cmd(srwi_pkg::CMD_LOCK, 23'h0, 16'h0000);
    check("lock outside", st[srwi_pkg::ST_REFUSED_BIT], 1'b1);
  endtask : t_exit
  task automatic t_reset_mid;
    run_cmd(srwi_pkg::CMD_ENTER, 23'h0, 16'h0000);
    do_reset();
    ahb(1'b0, srwi_pkg::REG_STATUS_OFS, 32'h0, st);
    check("region cleared", st[srwi_pkg::ST_REGION_BIT], 1'b0);
    flash_read(23'h10);
    check("main after reset", d, 32'h3C10);
  endtask : t_reset_mid
  initial begin
    do_reset();
    t_main();
    t_enter();
    t_program();
    t_lock();
    t_exit();
    t_reset_mid();
    report_and_stop();
  end
endmodule : test_srwi_host
